// file: pbs_pkg.sv
// Operation
// - All synchronous inputs sampled on rising edge
// - Either strobe captures address and chip selects
// - Two-bit burst counter steps on advance only
// - Burst order selectable, linear or interleaved
// - Processor and controller strobes both start accesses
// - Registered writes complete with internal timing
// - Byte lane controls select written bytes
// - Global write low writes every lane
// - Output enable and sleep act asynchronously
// - Read data leaves through output register
// - Burst reads run three-one-one-one
// - Deselect completes within one clock cycle
// - Array is 256K x 36 or 512K x 18
package pbs_pkg;

   // ----------------------------------------------------------------
   // Organisation
   // ----------------------------------------------------------------
   localparam int PBS_LANE_W       = 9;   // Eight data bits plus parity per lane
   localparam int PBS_AW_WIDE      = 18;  // 256K words deep
   localparam int PBS_LANES_WIDE   = 4;   // 36 bits wide
   localparam int PBS_AW_NARROW    = 19;  // 512K words deep
   localparam int PBS_LANES_NARROW = 2;   // 18 bits wide
   localparam int PBS_AW_MAX       = 19;  // Widest address of either organisation
   localparam int PBS_LANES_MAX    = 4;   // Most lanes of either organisation
   localparam int PBS_DW_MAX       = PBS_LANES_MAX * PBS_LANE_W;
   localparam int PBS_BURST_W      = 2;   // Burst counter width

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int PBS_CLK_PERIOD_NS = 4;  // 250 MHz
   localparam int PBS_READ_EDGES    = 2;  // Strobe edge to data on the pins
   localparam int PBS_DESEL_EDGES   = 1;  // Deselect edge to outputs released

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PBS_ST_IDLE  = 2'b01,
      PBS_ST_BURST = 2'b10
   } pbs_state_t;

   // Synchronous control pins, all active low except depth_select_high
   typedef struct packed {
      logic                     cpu_addr_strobe_n;
      logic                     ctl_addr_strobe_n;
      logic                     burst_advance_n;
      logic                     global_write_n;
      logic                     byte_write_gate_n;
      logic [PBS_LANES_MAX-1:0] byte_lane_write_n;
      logic                     pipelined_chip_select_n;
      logic                     depth_select_high;
      logic                     depth_select_low_n;
   } pbs_ctl_t;

   // Whole state of the core
   typedef struct packed {
      pbs_state_t               st;       // Access state
      logic [PBS_AW_MAX-1:0]    base;     // Address captured with the strobe
      logic                     rd_pend;  // Read beat waiting for the array
      logic [PBS_AW_MAX-1:0]    rd_addr;  // Address of that beat
      logic                     wr_pend;  // Write beat waiting for the array
      logic [PBS_AW_MAX-1:0]    wr_addr;  // Address of that beat
      logic [PBS_DW_MAX-1:0]    wr_data;  // Registered write data
      logic [PBS_LANES_MAX-1:0] wr_mask;  // Lanes to write
      logic [PBS_DW_MAX-1:0]    dout;     // Output pipeline register
      logic                     dq_en;    // Output register holds read data
   } pbs_core_t;

   // Whole state of the burst counter
   typedef struct packed {
      logic [PBS_BURST_W-1:0] start;     // Low address bits at the strobe
      logic [PBS_BURST_W-1:0] cnt;       // Beats advanced so far
   } pbs_ctr_t;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam pbs_core_t PBS_CORE_RST = '{st: PBS_ST_IDLE, default: '0};
   localparam pbs_ctr_t  PBS_CTR_RST  = '{default: '0};

endpackage

// file: pbs_burst_ctr.sv
`timescale 1ns/10ps
// --------------------------------------------------------------------
// Two-bit burst address counter
// --------------------------------------------------------------------
module pbs_burst_ctr (
   input  wire logic                           sys_clk_in,
   input  wire logic                           resetn_in,
   input  wire logic                           load_in,
   input  wire logic [pbs_pkg::PBS_BURST_W-1:0] start_in,
   input  wire logic                           advance_in,
   input  wire logic                           linear_in,
   output logic      [pbs_pkg::PBS_BURST_W-1:0] offset_out,
   output logic      [pbs_pkg::PBS_BURST_W-1:0] offset_nxt_out
);
   import pbs_pkg::*;

   pbs_ctr_t               q;        // Registered state
   pbs_ctr_t               d;        // Next state
   logic [PBS_BURST_W-1:0] cnt_nxt;  // Count after one more step

   // Linear order adds, interleaved order flips bits; both wrap in four
   function automatic logic [PBS_BURST_W-1:0] order_offs(
      input logic                   lin,
      input logic [PBS_BURST_W-1:0] s,
      input logic [PBS_BURST_W-1:0] c
   );
      order_offs = lin ? PBS_BURST_W'(s + c) : (s ^ c);
   endfunction

   // Offsets of the current and the following beat
   always_comb begin
      cnt_nxt        = PBS_BURST_W'(q.cnt + 1'b1);
      offset_out     = order_offs(linear_in, q.start, q.cnt);
      offset_nxt_out = order_offs(linear_in, q.start, cnt_nxt);
   end

   // Load wins over advance, so a new strobe always restarts the burst
   always_comb begin
      d = q;
      if (load_in) begin
         d.start = start_in;
         d.cnt   = '0;
      end else if (advance_in) begin
         d.cnt = cnt_nxt;
      end
   end

   // State register
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         q <= PBS_CTR_RST;
      end else begin
         q <= d;
      end
   end

endmodule

// file: pbs_sram_core.sv
`timescale 1ns/10ps
// --------------------------------------------------------------------
// Pipelined burst static memory, synchronous interface and array
// --------------------------------------------------------------------
module pbs_sram_core #(
   parameter int LANES  = pbs_pkg::PBS_LANES_WIDE,       // 4 or 2
   parameter int ADDR_W = pbs_pkg::PBS_AW_WIDE,          // 18 or 19
   parameter int DW     = LANES * pbs_pkg::PBS_LANE_W    // Data width
) (
   input  wire logic               sys_clk_in,
   input  wire logic               resetn_in,
   input  wire logic               mode_linear_in,
   input  wire logic [ADDR_W-1:0]  addr_in,
   input  wire logic [DW-1:0]      dq_in,
   input  wire pbs_pkg::pbs_ctl_t  ctl_in,
   input  wire logic               output_enable_n_in,
   input  wire logic               sleep_request_in,
   output logic      [DW-1:0]      dq_out,
   output logic                    dq_oe_out
);
   import pbs_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   // The array is sized from ADDR_W, so both organisations share this code
   localparam int DEPTH = 2 ** ADDR_W;                  // Words per lane

   pbs_core_t              q;          // Registered state
   pbs_core_t              d;          // Next state
   logic                   live;       // Not asleep, pins are heard
   logic                   strobe;     // Either address strobe asserted
   logic                   selected;   // Chip selects all true
   logic [LANES-1:0]       lane_we;    // Lanes that this cycle writes
   logic                   wr_req;     // Any lane writes
   logic                   start;      // This edge opens an access or deselects
   logic                   beat;       // This edge performs an array beat
   logic                   beat_wr;    // That beat is a write
   logic [PBS_AW_MAX-1:0]  beat_addr;  // Address of that beat
   logic                   ctr_load;   // Restart the burst counter
   logic                   ctr_adv;    // Step the burst counter
   logic [PBS_BURST_W-1:0] offs;       // Current burst offset
   logic [PBS_BURST_W-1:0] offs_nxt;   // Offset after one step
   logic [ADDR_W-1:0]      wr_idx;     // Array index of a pending write
   logic [ADDR_W-1:0]      rd_idx;     // Array index of a pending read
   logic [DW-1:0]          rd_word;    // Array output

   // ----------------------------------------------------------------
   // Pin decode
   // ----------------------------------------------------------------

   // Sleep holds off every access at once; the pins are not sampled
   // meaningfully while it is high
   assign live     = ~sleep_request_in;
   assign strobe   = live & (~ctl_in.cpu_addr_strobe_n | ~ctl_in.ctl_addr_strobe_n);
   assign selected = ~ctl_in.pipelined_chip_select_n & ctl_in.depth_select_high
                     & ~ctl_in.depth_select_low_n;

   // Per-lane write enables: global write forces every lane
   // Lanes above LANES are never decoded, so their pins are don't-care
   genvar gi;
   generate
      for (gi = 0; gi < LANES; gi++) begin : g_we
         assign lane_we[gi] = ~ctl_in.global_write_n
                              | (~ctl_in.byte_write_gate_n
                                 & ~ctl_in.byte_lane_write_n[gi]);
      end
   endgenerate
   assign wr_req = |lane_we;

   // ----------------------------------------------------------------
   // Burst counter
   // ----------------------------------------------------------------
   pbs_burst_ctr u_ctr (
      .sys_clk_in     (sys_clk_in),
      .resetn_in      (resetn_in),
      .load_in        (ctr_load),
      .start_in       (addr_in[PBS_BURST_W-1:0]),
      .advance_in     (ctr_adv),
      .linear_in      (mode_linear_in),
      .offset_out     (offs),
      .offset_nxt_out (offs_nxt)
   );

   // ----------------------------------------------------------------
   // Access control
   // ----------------------------------------------------------------

   // Every synchronous pin is sampled only through d into q at the rising edge
   always_comb begin
      d         = q;
      start     = 1'b0;
      beat      = 1'b0;
      beat_wr   = 1'b0;
      beat_addr = '0;
      ctr_load  = 1'b0;
      ctr_adv   = 1'b0;
      // Pending beats last exactly one cycle
      d.rd_pend = 1'b0;
      d.wr_pend = 1'b0;
      // Output pipeline stage: array data moves to the pins register
      d.dq_en   = q.rd_pend;
      if (q.rd_pend) begin
         d.dout = PBS_DW_MAX'(rd_word);
      end
      // Decide whether this edge starts an access or continues the burst
      unique case (q.st)
         PBS_ST_IDLE: begin
            // Only a strobe can wake the interface
            start = strobe;
         end
         PBS_ST_BURST: begin
            if (strobe) begin
               // A new strobe ends the running burst
               start = 1'b1;
            end else if (live) begin
               // Continuation beat; advance high holds the address
               beat      = 1'b1;
               beat_wr   = wr_req;
               ctr_adv   = ~ctl_in.burst_advance_n;
               beat_addr = {q.base[PBS_AW_MAX-1:PBS_BURST_W],
                            (ctr_adv ? offs_nxt : offs)};
            end
         end
      endcase
      // A strobe edge either captures a new access or deselects
      if (start) begin
         if (selected) begin
            // Capture address and chip selects, restart the burst
            d.st      = PBS_ST_BURST;
            d.base    = PBS_AW_MAX'(addr_in);
            ctr_load  = 1'b1;
            beat      = 1'b1;
            beat_addr = PBS_AW_MAX'(addr_in);
            // Processor strobe always opens with a read; write controls
            // only count under the controller strobe
            beat_wr   = ctl_in.cpu_addr_strobe_n & wr_req;
         end else begin
            // Deselect: no beat, output register empties next edge
            d.st = PBS_ST_IDLE;
         end
      end
      // Route the beat to the write or the read pipeline
      if (beat) begin
         if (beat_wr) begin
            // Register address, data and lanes; array write follows alone
            d.wr_pend = 1'b1;
            d.wr_addr = beat_addr;
            d.wr_data = PBS_DW_MAX'(dq_in);
            d.wr_mask = PBS_LANES_MAX'(lane_we);
         end else begin
            d.rd_pend = 1'b1;
            d.rd_addr = beat_addr;
         end
      end
   end

   // State register, synchronous reset
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         q <= PBS_CORE_RST;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Storage array
   // ----------------------------------------------------------------
   // Narrow organisation uses every captured bit; wide drops the top one
   assign wr_idx = q.wr_addr[ADDR_W-1:0];
   assign rd_idx = q.rd_addr[ADDR_W-1:0];

   // One array per lane so that each lane has a single writer; a read
   // never meets a write of the same beat pair, since one edge issues
   // only one beat
   generate
      for (gi = 0; gi < LANES; gi++) begin : g_lane
         logic [PBS_LANE_W-1:0] mem [DEPTH];

         // Self-timed write from the registered beat
         always_ff @(posedge sys_clk_in) begin
            if (q.wr_pend && q.wr_mask[gi]) begin
               mem[wr_idx] <= q.wr_data[gi*PBS_LANE_W +: PBS_LANE_W];
            end
         end
         assign rd_word[gi*PBS_LANE_W +: PBS_LANE_W] = mem[rd_idx];

         a_lane_write: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
            (q.wr_pend && q.wr_mask[gi]) |=>
               (mem[$past(wr_idx)] == $past(q.wr_data[gi*PBS_LANE_W +: PBS_LANE_W])))
            else $error("registered write did not reach the array");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Pins
   // ----------------------------------------------------------------

   // Data comes from the output register; the enable is gated without
   // the clock so that output enable and sleep act at once
   // Upper lanes of dout stay unused in the narrow organisation
   assign dq_out    = q.dout[DW-1:0];
   assign dq_oe_out = q.dq_en & ~output_enable_n_in & ~sleep_request_in;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);
   // All checks below run in the single clock domain of the core

   // Read opened by the processor strobe shows data two edges later
   a_first_read: assert property (
      (strobe && selected && !ctl_in.cpu_addr_strobe_n) |=> q.rd_pend ##1 q.dq_en)
      else $error("first read word not in output register on time");

   // Each continued read beat shows its word two edges later, like the first
   a_burst_rate: assert property (
      (q.st == PBS_ST_BURST && live && !strobe && !wr_req) |=> q.rd_pend ##1 q.dq_en)
      else $error("burst read word late");

   // Deselect empties the output register in one cycle
   a_desel_one: assert property (
      (strobe && !selected) |=> (q.st == PBS_ST_IDLE) ##1 !q.dq_en)
      else $error("deselect took more than one cycle");

   // Captured address follows the pins at the strobe
   a_addr_capture: assert property (
      (strobe && selected) |=> (q.base == PBS_AW_MAX'($past(addr_in))))
      else $error("address not captured with strobe");

   // Linear advance steps the offset by one, modulo four
   a_linear_step: assert property (
      (q.st == PBS_ST_BURST && live && !strobe && mode_linear_in
       && !ctl_in.burst_advance_n) |=> (offs == PBS_BURST_W'($past(offs) + 1'b1)))
      else $error("linear burst step wrong");

   // Advance high holds the burst address
   a_adv_hold: assert property (
      (q.st == PBS_ST_BURST && !strobe && ctl_in.burst_advance_n) |=> $stable(offs))
      else $error("burst counter moved without advance");

   // Global write low writes all lanes
   a_gw_all: assert property (
      (q.st == PBS_ST_BURST && live && !strobe && !ctl_in.global_write_n)
      |=> (q.wr_pend && q.wr_mask[LANES-1:0] == {LANES{1'b1}}))
      else $error("global write missed a lane");

   // Byte writes take exactly the lanes asked for
   a_byte_mask: assert property (
      (q.st == PBS_ST_BURST && live && !strobe && ctl_in.global_write_n
       && !ctl_in.byte_write_gate_n && wr_req)
      |=> (q.wr_mask[LANES-1:0] == ~$past(ctl_in.byte_lane_write_n[LANES-1:0])))
      else $error("byte lanes written do not match controls");

   // Processor strobe never writes in its own cycle
   a_cpu_no_write: assert property (
      (strobe && !ctl_in.cpu_addr_strobe_n) |=> !q.wr_pend)
      else $error("write taken with processor strobe");

   // Sleep or output enable high frees the bus at once
   a_async_off: assert property (
      (sleep_request_in || output_enable_n_in) |-> !dq_oe_out)
      else $error("data driven while disabled");

   // Idle interface ignores controls until a strobe arrives
   a_idle_quiet: assert property (
      (q.st == PBS_ST_IDLE && !strobe) |=> (!q.rd_pend && !q.wr_pend))
      else $error("beat issued while deselected");

   // Sleep holds the access state and issues no beat
   a_sleep_freeze: assert property (
      !live |=> (!q.rd_pend && !q.wr_pend && $stable(q.st)))
      else $error("access moved during sleep");

   // A strobe restarts the burst at the captured low address bits
   a_start_offset: assert property (
      (strobe && selected) |=> (offs == $past(addr_in[PBS_BURST_W-1:0])))
      else $error("burst did not start at strobe address");

   // Controller strobe with write controls registers a write beat
   a_ctl_write: assert property (
      (strobe && selected && ctl_in.cpu_addr_strobe_n && wr_req)
      |=> (q.wr_pend && q.wr_addr == PBS_AW_MAX'($past(addr_in))))
      else $error("controller write not registered");

   // Read data stands in the output register until the next read
   a_dout_hold: assert property (
      !q.rd_pend |=> $stable(q.dout))
      else $error("output register changed without a read");

   // Upper address bits stay fixed for the whole burst
   a_base_hold: assert property (
      (q.st == PBS_ST_BURST && !strobe) |=> $stable(q.base))
      else $error("burst base moved without a strobe");

   // Main scenarios
   c_four_reads: cover property (
      (strobe && selected) ##1 (!strobe && !ctl_in.burst_advance_n)[*3] ##2 q.dq_en);
   c_write_burst: cover property (
      (q.st == PBS_ST_BURST && !strobe && wr_req) ##1 q.wr_pend);
   c_deselect: cover property ((q.st == PBS_ST_BURST) ##0 (strobe && !selected));
   c_interleave: cover property (
      (q.st == PBS_ST_BURST && !mode_linear_in && ctr_adv));
   c_sleep_hold: cover property (q.st == PBS_ST_BURST && !live);

endmodule

// file: pbs_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Bus master model: processor or cache controller
// ----------------------------------------------------------------
module pbs_host_model (
   input  wire logic         sys_clk_in,
   output logic      [17:0]  addr_out,
   output logic      [35:0]  dq_out,
   output pbs_pkg::pbs_ctl_t ctl_out,
   output logic              oe_n_out,
   output logic              sleep_out
);
   import pbs_pkg::*;

   // Idle bus: strobes and write controls high, chip deselected
   initial begin
      ctl_out   = '1;
      addr_out  = '0;
      dq_out    = '0;
      oe_n_out  = 1'b0;
      sleep_out = 1'b0;
   end

   // One bus cycle, called just after a falling edge so the rising edge sees settled pins
   task automatic drive(input logic cpu_n, ctl_n, adv_n, gw_n, bwe_n,
                        input logic [3:0] ln_n, input logic [2:0] cs,
                        input logic [17:0] a, input logic [35:0] d,
                        input logic wr, oen, slp);
      ctl_out.cpu_addr_strobe_n = cpu_n;
      ctl_out.ctl_addr_strobe_n = ctl_n;
      ctl_out.burst_advance_n   = adv_n;
      ctl_out.global_write_n    = gw_n;
      ctl_out.byte_write_gate_n = bwe_n;
      ctl_out.byte_lane_write_n = ln_n;
      {ctl_out.pipelined_chip_select_n, ctl_out.depth_select_high,
       ctl_out.depth_select_low_n} = cs;
      addr_out  = a;
      // A master not writing leaves no stale word on the data lines
      dq_out    = wr ? d : ~dq_out;
      oe_n_out  = oen;
      sleep_out = slp;
   endtask
endmodule

// file: pipelined_burst_sram_tb_top.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Self-checking bench, wide organisation
// ----------------------------------------------------------------
module pipelined_burst_sram_tb_top;
   import pbs_pkg::*;
   logic        sys_clk_in = 1'b0;   // 250 MHz clock
   logic        resetn_in  = 1'b0;   // Synchronous reset
   logic        mode_linear_in = 1'b0; // Burst order
   logic [17:0] addr;                // Address pins
   logic [35:0] dq_w;                // Data toward the memory
   logic [35:0] dq_r;                // Data from the memory
   pbs_ctl_t    ctl;                 // Control pins
   logic        oen;                 // Output enable, low true
   logic        slp;                 // Sleep request
   logic        dq_oe;               // Memory drives the data pins
   int          n_errors = 0;        // Mismatches
   int          n_checks = 0;        // Comparisons
   logic [31:0] seed = 32'h2;        // Xorshift state
   logic [35:0] mem [int];           // Reference array
   bit          act;                 // Reference burst in progress
   logic [17:0] base;                // Reference captured address
   logic [1:0]  st, cnt;             // Reference start and step count
   bit          p1_v, p2_v;          // Read beats one and two edges back
   logic [35:0] p1_d, p2_d;          // Their expected words
   logic        p_oen = 1'b0;        // Gates applied during the current cycle
   logic        p_slp = 1'b0;
   logic [35:0] p_last = 36'h0;      // Word the output register holds

   // ----------------------------------------------------------------
   // Clock and instances
   // ----------------------------------------------------------------
   always #(PBS_CLK_PERIOD_NS / 2) sys_clk_in = ~sys_clk_in;

   pbs_sram_core #(.LANES(4), .ADDR_W(18)) DUT (
      .sys_clk_in         (sys_clk_in),
      .resetn_in          (resetn_in),
      .mode_linear_in     (mode_linear_in),
      .addr_in            (addr),
      .dq_in              (dq_w),
      .ctl_in             (ctl),
      .output_enable_n_in (oen),
      .sleep_request_in   (slp),
      .dq_out             (dq_r),
      .dq_oe_out          (dq_oe)
   );

   pbs_host_model host (
      .sys_clk_in (sys_clk_in),
      .addr_out   (addr),
      .dq_out     (dq_w),
      .ctl_out    (ctl),
      .oe_n_out   (oen),
      .sleep_out  (slp)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [35:0] r36();
      logic [63:0] w;
      w = {rnd(), rnd()};
      return w[35:0];
   endfunction

   task automatic check(input string what, input logic [35:0] exp, got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // One clock of the reference model: check the word due now, then predict the next edge
   task automatic beat(input logic cpu_n, ctl_n, adv_n, gw_n, bwe_n,
                       input logic [3:0] ln_n, input logic [2:0] cs,
                       input logic [17:0] a, input logic [35:0] d, input logic o, s);
      logic [3:0]  lanes;
      logic        rd;
      logic        wr;
      logic [17:0] ad;
      logic [35:0] m;
      @(negedge sys_clk_in);
      check("dq_oe", {35'h0, p2_v & ~p_oen & ~p_slp}, {35'h0, dq_oe});
      if (p2_v) p_last = p2_d;
      check("dq", p_last, dq_r);
      lanes = gw_n ? (bwe_n ? 4'h0 : ~ln_n) : 4'hf;
      rd = 1'b0;
      wr = 1'b0;
      if (!s && !(cpu_n && ctl_n)) begin
         // Strobe: capture, or deselect when chip selects are false
         act  = (cs == 3'b010);
         base = a;
         st   = a[1:0];
         cnt  = 2'h0;
         rd   = act && (!cpu_n || lanes == 4'h0);
         wr   = act && cpu_n && lanes != 4'h0;
      end else if (act && !s) begin
         if (!adv_n) cnt++;
         rd = (lanes == 4'h0);
         wr = !rd;
      end
      ad = {base[17:2], mode_linear_in ? st + cnt : st ^ cnt};
      if (wr) begin
         m = mem.exists(ad) ? mem[ad] : 'x;
         for (int i = 0; i < 4; i++) if (lanes[i]) m[i*9+:9] = d[i*9+:9];
         mem[ad] = m;
      end
      p2_v = p1_v;
      p2_d = p1_d;
      p1_v = rd;
      p1_d = (rd && mem.exists(ad)) ? mem[ad] : 'x;
      p_oen = o;
      p_slp = s;
      host.drive(cpu_n, ctl_n, adv_n, gw_n, bwe_n, ln_n, cs, a, d, wr, o, s);
      #1;
      if (o | s) check("dq_oe gated", 36'h0, {35'h0, dq_oe});
   endtask

   task automatic nop();
      beat(1, 1, 1, 1, 1, 4'hf, 3'b010, 18'(rnd()), r36(), 0, 0);
   endtask

   // Strobe with the pipelined select false ends any burst
   task automatic desel(input logic cpu);
      beat(!cpu, cpu, 1, 1, 1, 4'hf, 3'b110, 18'(rnd()), r36(), 0, 0);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [17:0] a;
      logic [31:0] w;
      repeat (16) @(negedge sys_clk_in);
      check("reset dq_oe", 36'h0, {35'h0, dq_oe});
      check("reset dq", 36'h0, dq_r);
      resetn_in = 1'b1;
      for (int md = 0; md < 2; md++) begin
         mode_linear_in = md[0];
         for (int t = 0; t < 8; t++) begin
            a = 18'(rnd());
            a[1:0] = t[1:0];
            // Burst write, global write overriding random lane controls
            for (int k = 0; k < 4; k++) begin
               w = rnd();
               beat(1, k != 0, k == 0, 0, w[0], w[4:1], 3'b010, a, r36(), 0, 0);
            end
            desel(t[0]);
            // Read burst, advancing every beat, on either strobe
            for (int k = 0; k < 4; k++) beat(t[0] || k != 0, !t[0] || k != 0, k == 0, 1, 1, 4'hf, 3'b010, a, r36(), 0, 0);
            desel(~t[0]);
            // Byte write under the controller strobe
            w = rnd();
            beat(1, 0, 1, 1, 0, w[3:0], 3'b010, a ^ 18'(t), r36(), 0, 0);
            desel(0);
            // Processor strobe with write controls set: must read, not write
            beat(0, w[4], 1, 0, 0, 4'h0, 3'b010, a ^ 18'(w[6:5]), r36(), 0, 0);
            // Depth selects false deselect as well
            beat(1, 0, 1, 1, 1, 4'hf, {1'b0, w[7], w[7]}, a, r36(), 0, 0);
            // Read burst with random advance, output enable and sleep
            for (int k = 0; k < 7; k++) begin
               w = rnd();
               beat(k != 0, 1, w[0], 1, 1, 4'hf, 3'b010, a, r36(), w[3:1] == 3'h0,
                    k != 0 && w[6:4] == 3'h0);
            end
            desel(1);
            nop();
            nop();
         end
      end
      print_verdict();
   end

   // Guard against a hang
   initial begin
      repeat (50000) @(posedge sys_clk_in);
      n_errors++;
      print_verdict();
   end
endmodule
